// ---- core/lfr_pkg.sv ----
// Purpose: Shared constants for the LED fault, thermal and retry controller.
// Assumes: One 20 MHz system clock; all inputs synchronous to it.
// Notes: Long counts are top-level parameters so a simulation can shorten them.
package lfr_pkg;
  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 20000000; // System clock rate.
  localparam int unsigned MIN_ON_NS = 8000; // Least LED on-time for valid detection.
  // Least time rounds up to whole cycles.
  localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned WAKE_FILTER_NS = 150000; // Dominant time needed to wake.
  localparam int unsigned WAKE_CYC = (WAKE_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned RETRY_LIMIT = 20; // Turn-on attempts per status read.
  // ==========================================================
  // Colour update field and fault codes
  // ==========================================================
  localparam int unsigned COLOUR_MODE_LSB = 6; // Field sits in byte 5, bits 6 and 7.
  localparam logic [1:0] COLOUR_STORE = 2'h1; // Store, do not apply.
  localparam logic [1:0] COLOUR_APPLY = 2'h2; // Apply the stored values.
  localparam logic [1:0] COLOUR_DISCARD = 2'h3; // Drop the received colour.
  localparam logic [2:0] FAULT_NONE = 3'h0; // No fault.
  localparam logic [2:0] FAULT_CATH_GND = 3'h2; // Cathode shorted to ground.
  localparam logic [2:0] FAULT_SENSE_SHORT = 3'h3; // Open sense or anode-cathode short.
  localparam logic [2:0] FAULT_LED_OPEN = 3'h5; // Open LED, no retry.
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [23:0] COLOUR_RESET = 24'h000000; // Colour after reset or sleep.
  localparam logic [3:0] STEPS_RESET = 4'h0; // No thermal reduction.
  localparam logic [3:0] STEPS_MAX = 4'hf; // Reduction saturates here.
  typedef enum logic [1:0] {
    LFR_AWAKE = 2'b01,
    LFR_ASLEEP = 2'b10
  } lfr_power_t;
endpackage

// ---- core/lfr_led_fault_retry.sv ----
// Purpose: Colour update, per-channel fault coding, thermal response, retry and sleep.
// Assumes: Fault and temperature comparators are synchronous levels from analog blocks.
// Notes: Sleep entry acts as a synchronous reset of every control register.
`timescale 1ns/1ns
`default_nettype none
module lfr_led_fault_retry #(
  parameter int unsigned RETRY_INTERVAL_CYC = 200000,
  parameter int unsigned TH_TIMEOUT_CYC = 20000000,
  parameter int unsigned WAKE_FILTER_CYC = lfr_pkg::WAKE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic colour_valid_i,
  input wire logic [7:0] colour_byte5_i,
  input wire logic [23:0] colour_data_i,
  input wire logic [2:0] channel_enable_i,
  input wire logic all_channels_switch_i,
  input wire logic all_channels_write_i,
  input wire logic [2:0] cathode_short_i,
  input wire logic [2:0] sense_short_i,
  input wire logic [2:0] led_open_i,
  input wire logic temp_warn_i,
  input wire logic temp_shutdown_i,
  input wire logic thermal_regulation_enable_i,
  input wire logic fault_off_scope_sel_i,
  input wire logic complete_status_query_i,
  input wire logic sleep_request_i,
  input wire logic lin_rx_i,
  output logic [23:0] colour_active_o,
  output logic [23:0] colour_stored_o,
  output logic [2:0] channel_cathode_output_o,
  output logic ballast_bias_output_o,
  output logic [8:0] channel_fault_code_o,
  output logic thermal_warning_flag_o,
  output logic thermal_shutdown_flag_o,
  output logic [3:0] thermal_reduction_steps_o,
  output logic retry_state_o,
  output logic asleep_o
);
  import lfr_pkg::*;

  // ==========================================================
  // Power state and wake filter
  // ==========================================================
  lfr_power_t power; // Awake or asleep.
  logic lin_armed; // Bus has been seen recessive while asleep.
  logic [31:0] wake_cnt; // Dominant time so far.
  wire sleeping = (power == LFR_ASLEEP);
  wire wake_hit = lin_armed && !lin_rx_i && (wake_cnt >= WAKE_FILTER_CYC - 1);

  // The wake counter only runs after a recessive level, so a bus stuck dominant cannot wake us.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power <= LFR_AWAKE;
      lin_armed <= 1'b0;
      wake_cnt <= 32'h0;
    end else begin
      case (power)
        LFR_AWAKE: begin
          if (sleep_request_i) begin
            power <= LFR_ASLEEP;
          end
          lin_armed <= 1'b0;
          wake_cnt <= 32'h0;
        end
        LFR_ASLEEP: begin
          if (wake_hit) begin
            power <= LFR_AWAKE;
          end
          lin_armed <= lin_rx_i ? 1'b1 : lin_armed;
          wake_cnt <= (lin_rx_i || !lin_armed) ? 32'h0 : wake_cnt + 32'h1;
        end
        default: begin
          power <= LFR_AWAKE;
        end
      endcase
    end
  end

  // ==========================================================
  // Colour update modes
  // ==========================================================
  wire [1:0] colour_mode = colour_byte5_i[COLOUR_MODE_LSB +: 2];

  // Mode 00 is not documented; it loads and applies at once, like a plain colour write.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      colour_active_o <= COLOUR_RESET;
      colour_stored_o <= COLOUR_RESET;
    end else if (sleeping) begin
      colour_active_o <= COLOUR_RESET;
      colour_stored_o <= COLOUR_RESET;
    end else if (colour_valid_i) begin
      case (colour_mode)
        COLOUR_STORE: colour_stored_o <= colour_data_i;
        COLOUR_APPLY: colour_active_o <= colour_stored_o;
        COLOUR_DISCARD: colour_stored_o <= colour_stored_o;
        default: begin
          colour_stored_o <= colour_data_i;
          colour_active_o <= colour_data_i;
        end
      endcase
    end
  end

  // ==========================================================
  // Per-channel fault detection and coding
  // ==========================================================
  logic [2:0] off_gate; // Channel held off by a ground short.
  logic bias_off; // Anode supply switched off.
  logic tsd_active; // Shutdown still in force.
  logic [2:0] new_retry_fault; // A retry fault appears this cycle.
  logic [2:0] cath_hit; // A ground short appears this cycle.
  wire [2:0] led_on = channel_enable_i & {3{all_channels_switch_i}} & ~off_gate
                      & {3{!tsd_active && !sleeping}};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      logic [7:0] on_cnt; // Continuous on-time, saturating at the validity limit.
      logic [2:0] code; // Latched fault code.
      wire valid_on = (on_cnt >= MIN_ON_CYC[7:0]);
      // A coded short counts again only while driven, so a failed retry turns off again.
      wire cath = cathode_short_i[g] && (led_on[g] || (code != FAULT_CATH_GND));
      wire sens = valid_on && sense_short_i[g] && (code == FAULT_NONE);
      wire opn = valid_on && led_open_i[g] && (code == FAULT_NONE);
      assign cath_hit[g] = cath && !sleeping;
      assign new_retry_fault[g] = (cath || sens) && !sleeping;
      assign channel_fault_code_o[3*g +: 3] = code;

      // Counts only while the channel drives, so short pulses never produce a sense or open fault.
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          on_cnt <= 8'h0;
        end else if (!led_on[g]) begin
          on_cnt <= 8'h0;
        end else if (!valid_on) begin
          on_cnt <= on_cnt + 8'h1;
        end
      end

      // A detection in the cycle of a status read wins over the clear.
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          code <= FAULT_NONE;
        end else if (sleeping) begin
          code <= FAULT_NONE;
        end else if (cath) begin
          code <= FAULT_CATH_GND;
        end else if (sens) begin
          code <= FAULT_SENSE_SHORT;
        end else if (opn) begin
          code <= FAULT_LED_OPEN;
        end else if (complete_status_query_i) begin
          code <= FAULT_NONE;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Retry sequencer with one shared interval timer
  // ==========================================================
  logic [31:0] retry_timer; // Time since the latest retry fault or attempt.
  logic [4:0] retry_count; // Attempts made since the last status read.
  wire any_new_fault = |new_retry_fault;
  wire retry_due = retry_state_o && (retry_timer >= RETRY_INTERVAL_CYC - 1);
  wire retry_left = (retry_count < RETRY_LIMIT[4:0]);
  wire [2:0] gate_set = fault_off_scope_sel_i ? {3{|cath_hit}} : cath_hit;

  // Open LED and sense faults never touch the gate; only a ground short switches off.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      retry_state_o <= 1'b0;
      retry_timer <= 32'h0;
      retry_count <= 5'h0;
      off_gate <= 3'h0;
      bias_off <= 1'b0;
    end else if (any_new_fault) begin
      retry_state_o <= 1'b1;
      retry_timer <= 32'h0;
      off_gate <= off_gate | gate_set;
      bias_off <= bias_off | (|cath_hit);
    end else if (sleeping || complete_status_query_i) begin // New faults are masked asleep.
      retry_state_o <= 1'b0;
      retry_timer <= 32'h0;
      retry_count <= 5'h0;
      off_gate <= 3'h0;
      bias_off <= 1'b0;
    end else if (retry_due && retry_left) begin
      retry_timer <= 32'h0;
      retry_count <= retry_count + 5'h1;
      off_gate <= 3'h0;
      bias_off <= 1'b0;
    end else if (retry_state_o && !retry_due) begin
      retry_timer <= retry_timer + 32'h1;
    end
  end

  // ==========================================================
  // Thermal flags, shutdown and regulation
  // ==========================================================
  logic [31:0] th_timer; // Time in the current reduction period.
  wire th_period_end = (thermal_reduction_steps_o != STEPS_RESET)
                       && (th_timer >= TH_TIMEOUT_CYC - 1);
  wire th_restore = all_channels_write_i && all_channels_switch_i;

  // Flags are cleared by the status read, but a present condition wins over the clear.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thermal_warning_flag_o <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
      tsd_active <= 1'b0;
    end else if (sleeping) begin
      thermal_warning_flag_o <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
      tsd_active <= 1'b0;
    end else begin
      thermal_warning_flag_o <= temp_warn_i
                                || (thermal_warning_flag_o && !complete_status_query_i);
      thermal_shutdown_flag_o <= temp_shutdown_i
                                 || (thermal_shutdown_flag_o && !complete_status_query_i);
      tsd_active <= temp_shutdown_i || (tsd_active && temp_warn_i);
    end
  end

  // First step on reaching warning, then one more per period while warning holds.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thermal_reduction_steps_o <= STEPS_RESET;
      th_timer <= 32'h0;
    end else if (sleeping || th_restore) begin
      thermal_reduction_steps_o <= STEPS_RESET;
      th_timer <= 32'h0;
    end else if (thermal_reduction_steps_o == STEPS_RESET) begin
      if (thermal_regulation_enable_i && temp_warn_i) begin
        thermal_reduction_steps_o <= 4'h1;
      end
      th_timer <= 32'h0;
    end else if (th_period_end) begin
      th_timer <= 32'h0;
      if (temp_warn_i && thermal_reduction_steps_o != STEPS_MAX) begin
        thermal_reduction_steps_o <= thermal_reduction_steps_o + 4'h1;
      end
    end else begin
      th_timer <= th_timer + 32'h1;
    end
  end

  // ==========================================================
  // Output drive
  // ==========================================================
  assign channel_cathode_output_o = led_on;
  assign ballast_bias_output_o = !sleeping && !bias_off && !tsd_active;
  assign asleep_o = sleeping;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_colour_store;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      colour_valid_i && !sleeping && colour_mode == COLOUR_STORE
      |=> colour_stored_o == $past(colour_data_i) && $stable(colour_active_o);
  endproperty
  a_colour_store: assert property (p_colour_store) else $error("store mode wrong");

  property p_colour_apply;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      colour_valid_i && !sleeping && colour_byte5_i[7:6] == 2'h2
      |=> colour_active_o == $past(colour_stored_o);
  endproperty
  a_colour_apply: assert property (p_colour_apply) else $error("apply mode wrong");

  sequence s_cath_fault;
    !sleeping && (|cath_hit);
  endsequence
  property p_cath_off;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      s_cath_fault ##0 !sleep_request_i ##1 !complete_status_query_i
      |-> !ballast_bias_output_o && retry_state_o;
  endproperty
  a_cath_off: assert property (p_cath_off) else $error("ground short not off");
  // Channel 2 is watched because it is the channel that is switched on from cold.
  property p_min_on;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $changed(channel_fault_code_o[8:6]) && channel_fault_code_o[8:6] == FAULT_LED_OPEN
      |-> $past(g_ch[2].on_cnt) >= MIN_ON_CYC[7:0];
  endproperty
  a_min_on: assert property (p_min_on) else $error("open fault before min on");
  property p_tsd_off;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      temp_shutdown_i && !sleeping |=> channel_cathode_output_o == 3'h0;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("LEDs on in shutdown");

  property p_warn_sticky;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      thermal_warning_flag_o && !complete_status_query_i && !sleeping
      |=> thermal_warning_flag_o;
  endproperty
  a_warn_sticky: assert property (p_warn_sticky) else $error("warning flag lost");

  sequence s_cooled;
    tsd_active && !temp_shutdown_i && !temp_warn_i ##1 !temp_shutdown_i;
  endsequence
  property p_resume;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      s_cooled |-> !tsd_active;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after cooling");

  property p_th_first;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !sleeping && !th_restore && thermal_reduction_steps_o == 4'h0
      && thermal_regulation_enable_i && temp_warn_i |=> thermal_reduction_steps_o == 4'h1;
  endproperty
  a_th_first: assert property (p_th_first) else $error("no first reduction step");

  property p_th_restore;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      th_restore |=> thermal_reduction_steps_o == 4'h0;
  endproperty
  a_th_restore: assert property (p_th_restore) else $error("steps not cleared");

  property p_query_clear;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      complete_status_query_i && !any_new_fault && !sleeping
      |=> !retry_state_o && retry_count == 5'h0;
  endproperty
  a_query_clear: assert property (p_query_clear) else $error("status read no clear");
  property p_retry_limit;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      retry_count <= RETRY_LIMIT[4:0];
  endproperty
  a_retry_limit: assert property (p_retry_limit) else $error("too many retries");
  property p_sleep;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !sleeping && sleep_request_i |=> ##1 channel_cathode_output_o == 3'h0
      && !ballast_bias_output_o && retry_count == 5'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not reset");
endmodule
`default_nettype wire

// ---- bench/lfr_led_model.sv ----
// Purpose: Behavioural LEDs, sense resistors and ballast seen by the fault comparators.
// Assumes: The bench injects each physical fault as a level per channel.
// Notes: A fault is only visible while current can flow through the channel.
`timescale 1ns/1ns
`default_nettype none
module lfr_led_model (
  input wire logic [2:0] drive_i,
  input wire logic bias_i,
  input wire logic [2:0] gnd_fault_i,
  input wire logic [2:0] sense_fault_i,
  input wire logic [2:0] open_fault_i,
  output logic [2:0] cathode_short_o,
  output logic [2:0] sense_short_o,
  output logic [2:0] led_open_o
);
  // ==========================================================
  // Comparators
  // ==========================================================
  // An undriven cathode carries no current, so a ground short shows only while driven.
  // This is harsher than a static fault: every retry turn-on re-detects the short.
  assign cathode_short_o = gnd_fault_i & drive_i;
  // Sense and open faults need the anode supply as well as cathode drive.
  assign sense_short_o = sense_fault_i & drive_i & {3{bias_i}};
  assign led_open_o = open_fault_i & drive_i & {3{bias_i}};
endmodule
`default_nettype wire

// ---- bench/lfr_led_fault_retry_tb.sv ----
// Purpose: Self-checking bench for the LED fault, thermal, retry and sleep controller.
// Assumes: Short timing parameters; inputs change 1 ns after the rising edge.
// Notes: Expected colours come from a bench function, never from the design.
`timescale 1ns/1ns
`default_nettype none
module lfr_led_fault_retry_tb;
  import lfr_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, colour_valid_i = 1'b0, sw = 1'b1, sw_wr = 1'b0;
  logic [7:0] byte5 = 8'h00;
  logic [23:0] cdata = 24'h000000, c_act, c_st;
  logic [2:0] en = 3'h7, gnd_f = 3'h0, sense_f = 3'h0, open_f = 3'h0;
  logic [2:0] cs, ss, lo, cath;
  logic warn = 1'b0, thermal_shutdown_flag = 1'b0, reg_en = 1'b0, scope = 1'b1, query = 1'b0;
  logic sleep_rq = 1'b0, lin = 1'b1, bias, twf, tsf, retry, asleep, prev;
  logic [8:0] codes;
  logic [3:0] steps;
  logic [47:0] sa; // Expected {stored, active} colour.
  int errors = 0, checked = 0, cycles = 0, rises;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
  // ==========================================================
  // Design, partner and clock
  // ==========================================================
  lfr_led_fault_retry #(.RETRY_INTERVAL_CYC(20), .TH_TIMEOUT_CYC(50), .WAKE_FILTER_CYC(10)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .colour_valid_i(colour_valid_i),
    .colour_byte5_i(byte5), .colour_data_i(cdata), .channel_enable_i(en),
    .all_channels_switch_i(sw), .all_channels_write_i(sw_wr), .cathode_short_i(cs),
    .sense_short_i(ss), .led_open_i(lo), .temp_warn_i(warn), .temp_shutdown_i(thermal_shutdown_flag),
    .thermal_regulation_enable_i(reg_en), .fault_off_scope_sel_i(scope),
    .complete_status_query_i(query), .sleep_request_i(sleep_rq), .lin_rx_i(lin),
    .colour_active_o(c_act), .colour_stored_o(c_st), .channel_cathode_output_o(cath),
    .ballast_bias_output_o(bias), .channel_fault_code_o(codes),
    .thermal_warning_flag_o(twf), .thermal_shutdown_flag_o(tsf),
    .thermal_reduction_steps_o(steps), .retry_state_o(retry), .asleep_o(asleep));
  lfr_led_model led (.drive_i(cath), .bias_i(bias), .gnd_fault_i(gnd_f),
    .sense_fault_i(sense_f), .open_fault_i(open_f), .cathode_short_o(cs),
    .sense_short_o(ss), .led_open_o(lo));
  // The clock toggles every half period of 25 ns.
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // A hang is cut short well beyond the roughly 1300 cycles the tests need.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // Helpers
  // ==========================================================
  // Wait n edges, then move 1 ns past the last one so outputs have settled.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Full status read, one cycle wide.
  task automatic read_status();
    query = 1'b1;
    step(1);
    query = 1'b0;
  endtask
  // Next {stored, active} pair for one colour command.
  function automatic logic [47:0] colour_next(input logic [1:0] m, input logic [23:0] d,
                                              input logic [47:0] s);
    case (m)
      2'h0: return {d, d};
      COLOUR_STORE: return {d, s[23:0]};
      COLOUR_APPLY: return {s[47:24], s[47:24]};
      default: return s;
    endcase
  endfunction
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    void'($urandom(32'hbc1d));
    step(10);
    nrst_i = 1'b1;
    step(2);
    `CHK({cath, bias, asleep, steps}, {3'h7, 1'b1, 1'b0, STEPS_RESET})
    // Colour modes: every code first, then random ones, back to back.
    sa = {COLOUR_RESET, COLOUR_RESET};
    for (int i = 0; i < 16; i++) begin
      byte5 = {(i < 4) ? 2'(i + 1) : 2'($urandom), 6'($urandom)};
      cdata = 24'($urandom);
      colour_valid_i = 1'b1;
      step(1);
      sa = colour_next(byte5[7:6], cdata, sa);
      `CHK({c_st, c_act}, sa)
    end
    colour_valid_i = 1'b0;
    // Ground short with all-off scope: code 010, bias low, every channel off.
    gnd_f = 3'h1;
    step(1);
    `CHK({codes, retry, bias, cath}, {6'h00, FAULT_CATH_GND, 1'b1, 1'b0, 3'h0})
    gnd_f = 3'h0;
    read_status();
    `CHK({codes, retry, bias, cath}, {9'h000, 1'b0, 1'b1, 3'h7})
    // Persistent short, failing channel only: exactly twenty turn-on attempts.
    scope = 1'b0;
    gnd_f = 3'h1;
    step(2);
    `CHK(cath, 3'h6)
    rises = 0;
    prev = 1'b0;
    for (int i = 0; i < 900; i++) begin
      step(1);
      if (cath[0] === 1'b1 && prev === 1'b0) rises++;
      prev = cath[0];
    end
    `CHK(rises, 20)
    `CHK({cath, retry}, {3'h6, 1'b1})
    gnd_f = 3'h0;
    read_status();
    step(1);
    `CHK({cath, codes}, {3'h7, 9'h000})
    // Sense fault on a long-driven channel: code 011, outputs stay on.
    sense_f = 3'h2;
    step(2);
    `CHK({codes, retry, bias, cath}, {3'h0, FAULT_SENSE_SHORT, 3'h0, 1'b1, 1'b1, 3'h7})
    sense_f = 3'h0;
    read_status();
    // Open LED right after turn-on is ignored until 8 us of drive.
    en = 3'h3;
    step(2);
    open_f = 3'h4;
    en = 3'h7;
    step(100);
    `CHK(codes, 9'h000)
    step(80);
    `CHK({codes, retry, bias, cath}, {FAULT_LED_OPEN, 6'h00, 1'b0, 1'b1, 3'h7})
    open_f = 3'h0;
    read_status();
    // Thermal regulation: one step, another per timeout while warm, then hold.
    reg_en = 1'b1;
    warn = 1'b1;
    step(1);
    `CHK({steps, twf}, {4'h1, 1'b1})
    step(50);
    `CHK(steps, 4'h2)
    warn = 1'b0;
    step(60);
    `CHK({steps, twf}, {4'h2, 1'b1})
    sw_wr = 1'b1;
    step(1);
    sw_wr = 1'b0;
    `CHK(steps, STEPS_RESET)
    reg_en = 1'b0;
    read_status();
    // Shutdown: off while above warning, back on once cool.
    warn = 1'b1;
    thermal_shutdown_flag = 1'b1;
    step(1);
    `CHK({cath, tsf}, {3'h0, 1'b1})
    thermal_shutdown_flag = 1'b0;
    step(20);
    `CHK({cath, tsf, steps}, {3'h0, 1'b1, STEPS_RESET})
    warn = 1'b0;
    step(2);
    `CHK(cath, 3'h7)
    // Sleep request resets registers; short dominant fails, long dominant wakes.
    sleep_rq = 1'b1;
    step(1);
    sleep_rq = 1'b0;
    step(1);
    `CHK({asleep, cath, bias, c_act, c_st, tsf}, {1'b1, 3'h0, 1'b0, 49'h0})
    lin = 1'b0;
    step(5);
    lin = 1'b1;
    step(3);
    `CHK(asleep, 1'b1)
    lin = 1'b0;
    step(13);
    lin = 1'b1;
    step(1);
    `CHK({asleep, cath, bias}, {1'b0, 3'h7, 1'b1})
    give_verdict();
  end
endmodule
`default_nettype wire
